// ===== src/etr_cond_pkg.sv
package etr_cond_pkg;
  localparam logic [7:0] SMC_ADDR      = 8'h08;
  localparam logic [15:0] SMC_RESET    = 16'h0000;
  localparam int         SFS_LSB       = 0;
  localparam int         TSC_LSB       = 4;
  localparam int         FLT_LSB       = 8;
  localparam int         PSC_LSB       = 12;
  localparam int         ECM2_BIT      = 14;
  localparam int         POL_BIT       = 15;
  localparam logic [15:0] SMC_WMASK    = 16'hffff;
  localparam logic [2:0] SFS_EXTCLK1   = 3'h7;
  localparam logic [2:0] SFS_RESET     = 3'h4;
  localparam logic [2:0] SFS_GATED     = 3'h5;
  localparam logic [2:0] SFS_TRIGGER   = 3'h6;
  localparam logic [2:0] TSC_INT_ZERO  = 3'h0;
  localparam logic [2:0] TSC_INT_ONE   = 3'h1;
  localparam logic [2:0] TSC_INT_TWO   = 3'h2;
  localparam logic [2:0] TSC_INT_THREE = 3'h3;
  localparam logic [2:0] TSC_TIED      = 3'h4;
  localparam logic [2:0] TSC_TI1       = 3'h5;
  localparam logic [2:0] TSC_TI2       = 3'h6;
  localparam logic [2:0] TSC_FILT_EXT  = 3'h7;
  localparam logic [7:0] DTS_DIV       = 8'h01;
endpackage

// ===== src/ext_trig_filter.sv
`timescale 1ns/10ps
// digital filter: sample at clock/div, switch after n equal samples
module ext_trig_filter (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] cfg_in,
  input  wire logic       din_in,
  output logic            dout_out
);
  typedef struct packed {
    logic [4:0] div_cnt;
    logic [3:0] run;
    logic       out;
  } filt_state_t;

  filt_state_t st_ff;
  filt_state_t nxt_st;
  logic [5:0]  div;
  logic [3:0]  len;

  always_comb begin
    div = 6'h01;
    len = 4'h1;
    case (cfg_in)
      4'h1: begin div = 6'h01; len = 4'h2; end
      4'h2: begin div = 6'h01; len = 4'h4; end
      4'h3: begin div = 6'h01; len = 4'h8; end
      4'h4: begin div = 6'h02; len = 4'h6; end
      4'h5: begin div = 6'h02; len = 4'h8; end
      4'h6: begin div = 6'h04; len = 4'h6; end
      4'h7: begin div = 6'h04; len = 4'h8; end
      4'h8: begin div = 6'h08; len = 4'h6; end
      4'h9: begin div = 6'h08; len = 4'h8; end
      4'ha: begin div = 6'h10; len = 4'h5; end
      4'hb: begin div = 6'h10; len = 4'h6; end
      4'hc: begin div = 6'h10; len = 4'h8; end
      4'hd: begin div = 6'h20; len = 4'h5; end
      4'he: begin div = 6'h20; len = 4'h6; end
      4'hf: begin div = 6'h20; len = 4'h8; end
      default: begin div = 6'h01; len = 4'h1; end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    if ({1'b0, st_ff.div_cnt} >= div - 6'h01) begin
      nxt_st.div_cnt = 5'h00;
      // sample tick: count agreeing samples differing from output
      if (din_in == st_ff.out) begin
        nxt_st.run = 4'h0;
      end else if (st_ff.run + 4'h1 >= len) begin
        nxt_st.out = din_in;
        nxt_st.run = 4'h0;
      end else begin
        nxt_st.run = st_ff.run + 4'h1;
      end
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 5'h01;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout_out = st_ff.out;
endmodule // ext_trig_filter

// ===== src/ext_trig_cond.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - filter samples at clock/DIV, changes after N agreeing samples; 1111 is 32/8.
// - prescale field 00 bypass, 01 div2, 10 div4, 11 div8.
// - mode 2 enable clocks counter from filtered trigger; mode 1 uses the selected trigger.
// - both external clock modes enabled: filtered trigger is the clock.
// - polarity bit clear passes trigger, set inverts it.
// - internal triggers 0,2,3 come from instances fifteen, three, seventeen.
// - filter code 0000 disables filtering, direct sampling.
// - slave function 111 counts rising edges of selected trigger.
module ext_trig_cond (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  input  wire logic        ext_trigger_pin_in,
  input  wire logic        timer_instance_fifteen_in,
  input  wire logic        internal_trig_one_in,
  input  wire logic        timer_instance_three_in,
  input  wire logic        timer_instance_seventeen_in,
  input  wire logic        ti_edge_in,
  input  wire logic        ti1_filtered_in,
  input  wire logic        ti2_filtered_in,
  output logic             filtered_ext_trigger_out,
  output logic             slave_trigger_input_out,
  output logic             count_tick_out,
  output logic             slave_trig_edge_out
);
  typedef struct packed {
    logic [15:0] smc;
    logic [15:0] rdata;
    logic        pol_q;
    logic [2:0]  psc_cnt;
    logic        psc_out;
    logic        sel_q;
    logic        filt_q;
    logic        tick;
    logic        edge_p;
  } cond_state_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic       out;
  } psc_step_t;

  cond_state_t st_ff;
  cond_state_t nxt_st;
  psc_step_t   psc_step;
  logic        pol_sig;
  logic        pol_rise;
  logic        filt;
  logic        filt_rise;
  logic        sel_trig;
  logic        sel_rise;
  logic        wr_hit;
  logic        rd_hit;
  logic        ecm2;
  logic        pol;
  logic [2:0]  sfs;
  logic [2:0]  tsc;
  logic [3:0]  flt;
  logic [1:0]  psc;

  function automatic logic [2:0] psc_mask(input logic [1:0] code);
    psc_mask = 3'((4'h1 << code) - 4'h1);
  endfunction

  // one address compare shared by the write and the read side
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == etr_cond_pkg::SMC_ADDR);
  endfunction

  function automatic logic rising(input logic now, input logic was);
    rising = now & ~was;
  endfunction

  // one active edge through the divider: high at wrap, low at half count
  function automatic psc_step_t psc_advance(
    input logic [2:0] cnt,
    input logic       out,
    input logic [1:0] code
  );
    psc_step_t  res;
    logic [2:0] top;
    logic [2:0] half;
    top     = psc_mask(code);
    half    = top >> 1;
    res.cnt = cnt;
    res.out = out;
    if (cnt >= top) begin
      res.cnt = 3'h0;
      res.out = 1'b1;
    end else begin
      res.cnt = cnt + 3'h1;
      if (cnt == half) begin
        res.out = 1'b0;
      end
    end
    psc_advance = res;
  endfunction

  // mode 2 wins over mode 1 when both are set
  function automatic logic tick_select(
    input logic       mode2,
    input logic [2:0] func,
    input logic       ext_rise,
    input logic       trg_rise
  );
    logic res;
    res = 1'b0;
    if (mode2) begin
      res = ext_rise;
    end else if (func == etr_cond_pkg::SFS_EXTCLK1) begin
      res = trg_rise;
    end
    tick_select = res;
  endfunction

  // unmapped reads and idle cycles both return zero
  function automatic logic [15:0] read_mux(
    input logic        hit,
    input logic [15:0] value
  );
    logic [15:0] res;
    res = 16'h0000;
    if (hit) begin
      res = value;
    end
    read_mux = res;
  endfunction

  assign sfs    = st_ff.smc[etr_cond_pkg::SFS_LSB +: 3];
  assign tsc    = st_ff.smc[etr_cond_pkg::TSC_LSB +: 3];
  assign flt    = st_ff.smc[etr_cond_pkg::FLT_LSB +: 4];
  assign psc    = st_ff.smc[etr_cond_pkg::PSC_LSB +: 2];
  assign ecm2   = st_ff.smc[etr_cond_pkg::ECM2_BIT];
  assign pol    = st_ff.smc[etr_cond_pkg::POL_BIT];
  assign wr_hit = wr_in & addr_hit(addr_in);
  assign rd_hit = rd_in & addr_hit(addr_in);
  // invert before anything else so every later stage sees active-high
  assign pol_sig   = ext_trigger_pin_in ^ pol;
  assign pol_rise  = rising(pol_sig, st_ff.pol_q);
  assign sel_rise  = rising(sel_trig, st_ff.sel_q);
  assign filt_rise = rising(filt, st_ff.filt_q);

  ext_trig_filter i_ext_trig_filter (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .cfg_in   (flt),
    .din_in   (st_ff.psc_out),
    .dout_out (filt)
  );

  always_comb begin
    sel_trig = 1'b0;
    if (tsc == etr_cond_pkg::TSC_INT_ZERO) begin
      sel_trig = timer_instance_fifteen_in;
    end else if (tsc == etr_cond_pkg::TSC_INT_ONE) begin
      sel_trig = internal_trig_one_in;
    end else if (tsc == etr_cond_pkg::TSC_INT_TWO) begin
      sel_trig = timer_instance_three_in;
    end else if (tsc == etr_cond_pkg::TSC_INT_THREE) begin
      sel_trig = timer_instance_seventeen_in;
    end else if (tsc == etr_cond_pkg::TSC_TIED) begin
      sel_trig = ti_edge_in;
    end else if (tsc == etr_cond_pkg::TSC_TI1) begin
      sel_trig = ti1_filtered_in;
    end else if (tsc == etr_cond_pkg::TSC_TI2) begin
      sel_trig = ti2_filtered_in;
    end else begin
      sel_trig = filt;
    end
  end

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.pol_q = pol_sig;
    psc_step     = psc_advance(st_ff.psc_cnt, st_ff.psc_out, psc);
    // bypass follows the pin level; divided modes move only on active edges
    if (psc == 2'h0) begin
      nxt_st.psc_out = pol_sig;
      nxt_st.psc_cnt = 3'h0;
    end else if (pol_rise) begin
      nxt_st.psc_cnt = psc_step.cnt;
      nxt_st.psc_out = psc_step.out;
    end
    nxt_st.sel_q  = sel_trig;
    nxt_st.filt_q = filt;
    nxt_st.edge_p = sel_rise;
    nxt_st.tick   = tick_select(ecm2, sfs, filt_rise, sel_rise);
    nxt_st.rdata  = read_mux(rd_hit, st_ff.smc);
    if (wr_hit) begin
      nxt_st.smc = wdata_in & etr_cond_pkg::SMC_WMASK;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
      st_ff.smc <= etr_cond_pkg::SMC_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out = st_ff.rdata;
  assign filtered_ext_trigger_out = st_ff.filt_q;
  assign slave_trigger_input_out = st_ff.sel_q;
  assign count_tick_out = st_ff.tick;
  assign slave_trig_edge_out = st_ff.edge_p;
endmodule // ext_trig_cond

// ===== tb/trig_partner.sv
`timescale 1ns/10ps
module trig_partner (
  input  wire logic       mclk_in,
  input  wire logic       run_in,
  input  wire logic       lvl_in,
  input  wire logic [2:0] peer_in,
  output logic            pin_out = 1'b0,
  output logic      [2:0] peer_out = 3'h0
);
  logic [1:0] ph_ff = 2'h0;
  // period 4 keeps the raw pin at the quarter-clock limit
  always_ff @(posedge mclk_in) begin
    ph_ff    <= ph_ff + 2'h1;
    peer_out <= peer_in;
    pin_out  <= run_in ? ph_ff[1] : lvl_in;
  end
endmodule // trig_partner

// ===== tb/ext_trig_cond_asserts.sv
`timescale 1ns/10ps
module ext_trig_cond_check (
  input wire logic        mclk_in, rst_in, wr_in, rd_in,
  input wire logic [7:0]  addr_in,
  input wire logic [15:0] wdata_in, rdata_out,
  input wire logic        ext_trigger_pin_in, timer_instance_fifteen_in,
  input wire logic        timer_instance_three_in,
  input wire logic        timer_instance_seventeen_in,
  input wire logic        filtered_ext_trigger_out,
  input wire logic        slave_trigger_input_out, count_tick_out,
  input wire logic        slave_trig_edge_out
);
  logic [15:0] cfg_ff;
  logic [3:0]  quiet_ff;
  // quiet counts cycles since the last write, so old settings drain first
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_ff   <= 16'h0000;
      quiet_ff <= 4'h0;
    end else if (wr_in && addr_in == 8'h08) begin
      cfg_ff   <= wdata_in;
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hf) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_rd_mapped: assert property (rd_in && addr_in == 8'h08 |=>
    rdata_out == $past(cfg_ff)) else $error("read data wrong");
  a_rd_idle: assert property (!(rd_in && addr_in == 8'h08) |=>
    rdata_out == 16'h0000) else $error("read data not zero");
  a_direct_path: assert property (
    quiet_ff > 4'h5 && cfg_ff[13:8] == 6'h00 |-> filtered_ext_trigger_out ==
    ($past(ext_trigger_pin_in, 3) ^ cfg_ff[15])) else $error("direct path");
  a_itr_zero: assert property (quiet_ff > 4'h2 && cfg_ff[6:4] == 3'h0 |->
    slave_trigger_input_out == $past(timer_instance_fifteen_in))
    else $error("code 0 source");
  a_itr_two: assert property (quiet_ff > 4'h2 && cfg_ff[6:4] == 3'h2 |->
    slave_trigger_input_out == $past(timer_instance_three_in))
    else $error("code 2 source");
  a_itr_three: assert property (quiet_ff > 4'h2 && cfg_ff[6:4] == 3'h3 |->
    slave_trigger_input_out == $past(timer_instance_seventeen_in))
    else $error("code 3 source");
  a_tick_mode2: assert property (quiet_ff > 4'h2 && cfg_ff[14] &&
    $rose(filtered_ext_trigger_out) |-> count_tick_out) else $error("mode 2");
  a_tick_mode1: assert property (quiet_ff > 4'h2 && !cfg_ff[14] &&
    cfg_ff[2:0] == 3'h7 && $rose(slave_trigger_input_out) |-> count_tick_out)
    else $error("mode 1");
  a_trig_edge: assert property (
    $rose(slave_trigger_input_out) |-> slave_trig_edge_out)
    else $error("trigger edge pulse missing");
endmodule // ext_trig_cond_check
bind ext_trig_cond ext_trig_cond_check i_ext_trig_cond_check (.*);

// ===== tb/test_ext_trig_cond.sv
`timescale 1ns/10ps
module test_ext_trig_cond;
  logic        mclk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic        run = 1'b0, lvl = 1'b0, pin, fet, sti, tick;
  logic [7:0]  addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000, rdata_out, d;
  logic [2:0]  peer_set = 3'h0, peer;
  logic [2:0]  src_code [3] = '{3'h0, 3'h2, 3'h3};
  int          mismatches = 0, cmp_count = 0, n, e;
  always #5 mclk_in = ~mclk_in;
  trig_partner i_trig_partner (.mclk_in, .run_in(run), .lvl_in(lvl),
    .peer_in(peer_set), .pin_out(pin), .peer_out(peer));
  ext_trig_cond i_ext_trig_cond (.mclk_in, .rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .ext_trigger_pin_in(pin),
    .timer_instance_fifteen_in(peer[0]), .internal_trig_one_in(1'b0),
    .timer_instance_three_in(peer[1]), .timer_instance_seventeen_in(peer[2]),
    .ti_edge_in(1'b0), .ti1_filtered_in(1'b0), .ti2_filtered_in(1'b0),
    .filtered_ext_trigger_out(fet), .slave_trigger_input_out(sti),
    .count_tick_out(tick), .slave_trig_edge_out());
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic ticks(int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge mclk_in);
      #1 n += int'(tick);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(8'h08);
    chk("reset_value", 16'h0000, d);
    wr(8'h08, 16'h5a3c);
    rd(8'h08);
    chk("readback", 16'h5a3c, d);
    wr(8'h0c, 16'hffff);
    rd(8'h0c);
    chk("unmapped", 16'h0000, d);
    $display("done registers");
    for (int i = 0; i < 3; i++) begin
      wr(8'h08, {9'h000, src_code[i], 4'h0});
      peer_set <= 3'h1 << i;
      repeat (4) @(posedge mclk_in);
      #1 chk("source_hi", 16'h1, {15'h0, sti});
      @(posedge mclk_in);
      peer_set <= ~(3'h1 << i);
      repeat (4) @(posedge mclk_in);
      #1 chk("source_lo", 16'h0, {15'h0, sti});
    end
    $display("done trigger sources");
    wr(8'h08, 16'h8000);
    repeat (6) @(posedge mclk_in);
    #1 chk("inverted_low", 16'h1, {15'h0, fet});
    wr(8'h08, 16'h0f00);
    repeat (400) @(posedge mclk_in);
    lvl <= 1'b1;
    repeat (200) @(posedge mclk_in);
    lvl <= 1'b0;
    repeat (40) @(posedge mclk_in);
    #1 chk("short_pulse", 16'h0, {15'h0, fet});
    lvl <= 1'b1;
    for (n = 0; n < 400 && fet !== 1'b1; n++) begin
      @(posedge mclk_in);
      #1;
    end
    chk("long_level", 16'h1, {15'h0, fet});
    if (n == 400) summarize();
    $display("done filter");
    peer_set <= 3'h0;
    run      <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      wr(8'h08, {2'b01, 2'(p), 12'h007});
      repeat (16) @(posedge mclk_in);
      ticks(256);
      e = 64 >> p;
      chk("tick_count", 16'(e), 16'((n - e) * (n - e) <= 1 ? e : n));
    end
    $display("done prescaler");
    wr(8'h08, 16'h4006);
    repeat (16) @(posedge mclk_in);
    ticks(256);
    e = 64;
    chk("mode2_trig_mode", 16'(e), 16'((n - e) * (n - e) <= 1 ? e : n));
    $display("done mode 2 with slave mode");
    wr(8'h08, 16'h0007);
    repeat (4) @(posedge mclk_in);
    ticks(64);
    chk("mode1_idle", 16'h0, 16'(n));
    peer_set <= 3'h1;
    ticks(8);
    chk("mode1_edge", 16'h1, 16'(n));
    $display("done mode 1");
    summarize();
  end
endmodule // test_ext_trig_cond
